// ==== logic/fcsm_pkg.sv ====
// Constants and types shared by the flash bank command state machine.
package fcsm_pkg;
  localparam int BANK_W = 4;
  localparam int NUM_BANKS = 16;
  localparam int CMD_W = 8;

  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_SIG = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
  localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN_CONFIRM = 8'h2f;
  localparam logic [7:0] CMD_SET_CFG_CONFIRM = 8'h03;

  typedef enum logic [1:0] {
    FCSM_OUT_ARRAY  = 2'h0,
    FCSM_OUT_STATUS = 2'h1,
    FCSM_OUT_SIG    = 2'h2,
    FCSM_OUT_QUERY  = 2'h3
  } fcsm_out_t;

  localparam fcsm_out_t OUT_RESET = FCSM_OUT_ARRAY;

  typedef enum logic [5:0] {
    FCSM_READY      = 6'h01,
    FCSM_LOCK_SETUP = 6'h02,
    FCSM_OTP_SETUP  = 6'h04,
    FCSM_OTP_BUSY   = 6'h08,
    FCSM_OTP_BUSY_IS = 6'h10,
    FCSM_ILLEGAL    = 6'h20
  } fcsm_state_t;
endpackage

// ==== logic/fcsm_bank_mem.sv ====
// Per-bank output state table with registered read port.
`timescale 1ns/10ps
`default_nettype none
module fcsm_bank_mem (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic [fcsm_pkg::BANK_W-1:0] i_wr_bank,
  input wire fcsm_pkg::fcsm_out_t i_wr_val,
  input wire logic [fcsm_pkg::BANK_W-1:0] i_rd_bank,
  output var fcsm_pkg::fcsm_out_t o_rd_val
);
  fcsm_pkg::fcsm_out_t mem_q [fcsm_pkg::NUM_BANKS];
  fcsm_pkg::fcsm_out_t mem_d [fcsm_pkg::NUM_BANKS];
  fcsm_pkg::fcsm_out_t rd_q;
  fcsm_pkg::fcsm_out_t rd_d;

  genvar g;
  generate
    for (g = 0; g < fcsm_pkg::NUM_BANKS; g++) begin : g_bank
      always_comb begin
        mem_d[g] = mem_q[g];
        if (i_ce && i_wr_en &&
            i_wr_bank == fcsm_pkg::BANK_W'(g)) begin
          mem_d[g] = i_wr_val;
        end
      end
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          mem_q[g] <= fcsm_pkg::OUT_RESET;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_d = rd_q;
    if (i_ce) begin
      rd_d = mem_q[i_rd_bank];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= fcsm_pkg::OUT_RESET;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign o_rd_val = rd_q;
endmodule
`default_nettype wire

// ==== logic/fcsm_top.sv ====
// Command front end: bank output states and lock/OTP command sequencing.
// Summary of operation
// - Output change only affects the addressed bank.
// - Four output kinds, chosen by last command.
// - Bank keeps state until written again.
// - Next state ignores bank output state.
// - Power-up puts every bank in array read.
// - Setup commands ignored while busy, except in OTP busy, where they move to FCSM_OTP_BUSY_IS.
// - 60h enters lock setup, C0h OTP setup.
// - Lock setup confirms or errors back to ready.
// - 70h status, 50h clears, 90h/98h signature/query.
`timescale 1ns/10ps
`default_nettype none
module fcsm_top (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [fcsm_pkg::BANK_W-1:0] i_wr_bank,
  input wire logic [fcsm_pkg::CMD_W-1:0] i_wr_data,
  input wire logic [fcsm_pkg::BANK_W-1:0] i_rd_bank,
  input wire logic i_pec_busy,
  input wire logic i_pec_done,
  output var fcsm_pkg::fcsm_out_t o_rd_sel,
  output var fcsm_pkg::fcsm_state_t o_state,
  output logic o_lock_stb,
  output logic o_lockdown_stb,
  output logic o_cfg_stb,
  output logic [fcsm_pkg::BANK_W-1:0] o_op_bank,
  output logic [fcsm_pkg::CMD_W-1:0] o_otp_word,
  output logic o_otp_start,
  output logic o_status_clr,
  output logic o_lock_err
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  fcsm_pkg::fcsm_state_t state_q, state_d;
  logic lock_stb_q, lock_stb_d;
  logic lockdown_stb_q, lockdown_stb_d;
  logic cfg_stb_q, cfg_stb_d;
  logic otp_start_q, otp_start_d;
  logic status_clr_q, status_clr_d;
  logic lock_err_q, lock_err_d;
  logic [fcsm_pkg::BANK_W-1:0] op_bank_q, op_bank_d;
  logic [fcsm_pkg::CMD_W-1:0] otp_word_q, otp_word_d;
  logic out_wr;
  fcsm_pkg::fcsm_out_t out_val;
  logic wr;

  // The reset is released through two flops so that release is synchronous.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign wr = i_ce && i_wr;

  // Output kind per command; decided from the command only, not the state
  // the bank currently presents.
  always_comb begin
    out_wr = 1'b0;
    out_val = fcsm_pkg::FCSM_OUT_ARRAY;
    // Setup second cycles carry data, and the illegal state freezes output.
    if (wr && (state_q == fcsm_pkg::FCSM_READY ||
               state_q == fcsm_pkg::FCSM_OTP_BUSY)) begin
      unique case (i_wr_data)
        fcsm_pkg::CMD_READ_ARRAY: begin
          out_wr = 1'b1;
          out_val = fcsm_pkg::FCSM_OUT_ARRAY;
        end
        fcsm_pkg::CMD_READ_STATUS: begin
          out_wr = 1'b1;
          out_val = fcsm_pkg::FCSM_OUT_STATUS;
        end
        fcsm_pkg::CMD_READ_SIG: begin
          out_wr = 1'b1;
          out_val = fcsm_pkg::FCSM_OUT_SIG;
        end
        fcsm_pkg::CMD_READ_QUERY: begin
          out_wr = 1'b1;
          out_val = fcsm_pkg::FCSM_OUT_QUERY;
        end
        default: begin
          out_wr = 1'b0;
        end
      endcase
    end
  end

  fcsm_bank_mem u_bank_mem (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_wr_en(out_wr),
    .i_wr_bank(i_wr_bank),
    .i_wr_val(out_val),
    .i_rd_bank(i_rd_bank),
    .o_rd_val(o_rd_sel)
  );

  always_comb begin
    state_d = state_q;
    lock_stb_d = 1'b0;
    lockdown_stb_d = 1'b0;
    cfg_stb_d = 1'b0;
    otp_start_d = 1'b0;
    status_clr_d = 1'b0;
    lock_err_d = lock_err_q;
    op_bank_d = op_bank_q;
    otp_word_d = otp_word_q;
    if (wr && i_wr_data == fcsm_pkg::CMD_CLEAR_STATUS &&
        state_q != fcsm_pkg::FCSM_LOCK_SETUP &&
        state_q != fcsm_pkg::FCSM_OTP_SETUP) begin
      status_clr_d = 1'b1;
      lock_err_d = 1'b0;
    end
    unique case (state_q)
      fcsm_pkg::FCSM_READY: begin
        if (wr && !i_pec_busy) begin
          if (i_wr_data == fcsm_pkg::CMD_LOCK_SETUP) begin
            state_d = fcsm_pkg::FCSM_LOCK_SETUP;
            op_bank_d = i_wr_bank;
          end else if (i_wr_data == fcsm_pkg::CMD_OTP_SETUP) begin
            state_d = fcsm_pkg::FCSM_OTP_SETUP;
            op_bank_d = i_wr_bank;
          end
        end
      end
      fcsm_pkg::FCSM_LOCK_SETUP: begin
        if (wr && !i_pec_busy) begin
          state_d = fcsm_pkg::FCSM_READY;
          op_bank_d = i_wr_bank;
          unique case (i_wr_data)
            fcsm_pkg::CMD_LOCK_CONFIRM: lock_stb_d = 1'b1;
            fcsm_pkg::CMD_LOCKDOWN_CONFIRM: lockdown_stb_d = 1'b1;
            fcsm_pkg::CMD_SET_CFG_CONFIRM: cfg_stb_d = 1'b1;
            default: lock_err_d = 1'b1;
          endcase
        end
      end
      fcsm_pkg::FCSM_OTP_SETUP: begin
        if (wr && !i_pec_busy) begin
          state_d = fcsm_pkg::FCSM_OTP_BUSY;
          otp_word_d = i_wr_data;
          otp_start_d = 1'b1;
        end
      end
      fcsm_pkg::FCSM_OTP_BUSY: begin
        if (i_ce && i_pec_done) begin
          state_d = fcsm_pkg::FCSM_READY;
        end else if (wr && (i_wr_data == fcsm_pkg::CMD_LOCK_SETUP ||
                            i_wr_data == fcsm_pkg::CMD_OTP_SETUP)) begin
          state_d = fcsm_pkg::FCSM_OTP_BUSY_IS;
        end
      end
      fcsm_pkg::FCSM_OTP_BUSY_IS: begin
        // A write without completion returns to plain busy; completion here, even with a write, is
        // illegal because a setup was left hanging.
        if (i_ce && i_pec_done) begin
          state_d = fcsm_pkg::FCSM_ILLEGAL;
        end else if (wr) begin
          state_d = fcsm_pkg::FCSM_OTP_BUSY;
        end
      end
      fcsm_pkg::FCSM_ILLEGAL: begin
        // Only clearing the status lets software leave the illegal state.
        if (wr && i_wr_data == fcsm_pkg::CMD_CLEAR_STATUS) begin
          state_d = fcsm_pkg::FCSM_READY;
        end
      end
      default: begin
        state_d = fcsm_pkg::FCSM_READY;
      end
    endcase
    if (!i_ce) begin
      state_d = state_q;
      lock_stb_d = lock_stb_q;
      lockdown_stb_d = lockdown_stb_q;
      cfg_stb_d = cfg_stb_q;
      otp_start_d = otp_start_q;
      status_clr_d = status_clr_q;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= fcsm_pkg::FCSM_READY;
      lock_stb_q <= 1'b0;
      lockdown_stb_q <= 1'b0;
      cfg_stb_q <= 1'b0;
      otp_start_q <= 1'b0;
      status_clr_q <= 1'b0;
      lock_err_q <= 1'b0;
      op_bank_q <= 4'h0;
      otp_word_q <= 8'h00;
    end else begin
      state_q <= state_d;
      lock_stb_q <= lock_stb_d;
      lockdown_stb_q <= lockdown_stb_d;
      cfg_stb_q <= cfg_stb_d;
      otp_start_q <= otp_start_d;
      status_clr_q <= status_clr_d;
      lock_err_q <= lock_err_d;
      op_bank_q <= op_bank_d;
      otp_word_q <= otp_word_d;
    end
  end

  assign o_state = state_q;
  assign o_lock_stb = lock_stb_q;
  assign o_lockdown_stb = lockdown_stb_q;
  assign o_cfg_stb = cfg_stb_q;
  assign o_otp_start = otp_start_q;
  assign o_status_clr = status_clr_q;
  assign o_lock_err = lock_err_q;
  assign o_op_bank = op_bank_q;
  assign o_otp_word = otp_word_q;
endmodule
`default_nettype wire

// ==== test/fcsm_top_props.sv ====
// Port checker for the flash bank command state machine.
`timescale 1ns/10ps
`default_nettype none
module fcsm_top_props (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [fcsm_pkg::CMD_W-1:0] i_wr_data,
  input wire logic i_pec_busy,
  input wire logic i_pec_done,
  input wire fcsm_pkg::fcsm_state_t o_state,
  input wire logic o_lock_stb,
  input wire logic o_lockdown_stb,
  input wire logic o_cfg_stb,
  input wire logic o_status_clr,
  input wire logic o_lock_err
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire logic go = i_ce && i_wr && !i_pec_busy;
  wire logic rdy = o_state == 6'h01;
  wire logic lks = o_state == 6'h02;
  wire logic [7:0] d = i_wr_data;
  property p_ls; rdy && go && d == 8'h60 |=> lks; endproperty
  a_ls: assert property (p_ls) else $error("lock setup missed");
  property p_os; rdy && go && d == 8'hc0 |=> o_state == 6'h04; endproperty
  a_os: assert property (p_os) else $error("otp setup missed");
  property p_cf; lks && go && d == 8'h2f |=> o_lockdown_stb && rdy; endproperty
  a_cf: assert property (p_cf) else $error("lock-down missed");
  property p_er;
    lks && go && !(d inside {8'h01, 8'h2f, 8'h03}) |=> o_lock_err && rdy;
  endproperty
  a_er: assert property (p_er) else $error("lock error missed");
  // Ready and lock setup must not advance while the controller is busy.
  property p_bz;
    (rdy || lks) && i_ce && i_wr && i_pec_busy |=> $stable(o_state);
  endproperty
  a_bz: assert property (p_bz) else $error("busy write acted");
  property p_dn; o_state == 6'h08 && i_ce && i_pec_done |=> rdy; endproperty
  a_dn: assert property (p_dn) else $error("otp done missed");
  property p_cl;
    rdy && i_ce && i_wr && d == 8'h50 |=> o_status_clr && !o_lock_err;
  endproperty
  a_cl: assert property (p_cl) else $error("status clear missed");
  property p_pl; o_cfg_stb || o_lock_stb |-> $past(lks) && rdy; endproperty
  a_pl: assert property (p_pl) else $error("strobe without setup");
endmodule
bind fcsm_top fcsm_top_props fcsm_top_props_inst (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_ce(i_ce), .i_wr(i_wr), .i_wr_data(i_wr_data),
  .i_pec_busy(i_pec_busy), .i_pec_done(i_pec_done), .o_state(o_state),
  .o_lock_stb(o_lock_stb), .o_lockdown_stb(o_lockdown_stb),
  .o_cfg_stb(o_cfg_stb), .o_status_clr(o_status_clr),
  .o_lock_err(o_lock_err));
`default_nettype wire

// ==== test/fcsm_pec_model.sv ====
// Program/erase controller model answering otp starts.
`timescale 1ns/10ps
`default_nettype none
module fcsm_pec_model #(parameter int LAT = 4) (
  input wire logic i_mclk,
  input wire logic i_start,
  input wire logic i_hold,
  output logic o_busy,
  output logic o_done
);
  int cnt = 0;
  logic act = 1'b0;
  // Hold lets the bench fake a busy controller with no operation running.
  assign o_busy = act | i_hold;
  initial o_done = 1'b0;
  always @(posedge i_mclk) begin
    o_done <= 1'b0;
    if (i_start) begin
      act <= 1'b1;
      cnt <= LAT;
    end else if (cnt == 1) begin
      act <= 1'b0;
      o_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ==== test/test_fcsm_top.sv ====
// Self-checking bench for the flash bank command state machine.
`timescale 1ns/10ps
`default_nettype none
module test_fcsm_top;
  logic clk = 0, nrst = 0, ce = 1, wr = 0, hold = 0;
  logic [3:0] wb = 0, rb = 0, ob;
  logic [7:0] wd = 0, ow;
  fcsm_pkg::fcsm_out_t sel;
  fcsm_pkg::fcsm_state_t st;
  logic ls, lds, cs, os, sc, le, busy, done;
  int fails = 0;
  int compares = 0;
  fcsm_top fcsm_top_inst (.i_mclk(clk), .i_nrst(nrst), .i_ce(ce), .i_wr(wr),
    .i_wr_bank(wb), .i_wr_data(wd), .i_rd_bank(rb), .i_pec_busy(busy),
    .i_pec_done(done), .o_rd_sel(sel), .o_state(st), .o_lock_stb(ls),
    .o_lockdown_stb(lds), .o_cfg_stb(cs), .o_op_bank(ob), .o_otp_word(ow),
    .o_otp_start(os), .o_status_clr(sc), .o_lock_err(le));
  fcsm_pec_model fcsm_pec_model_inst (.i_mclk(clk), .i_start(os),
    .i_hold(hold), .o_busy(busy), .o_done(done));
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Writes one command cycle to bank b, with wr high for one clock edge.
  task automatic w(logic [3:0] b, logic [7:0] d);
    @(negedge clk);
    wr = 1;
    wb = b;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rd(logic [3:0] b, logic [1:0] e);
    @(negedge clk);
    rb = b;
    repeat (2) @(negedge clk);
    chk("rd_sel", sel, e);
  endtask
  task automatic wait_st(logic [5:0] e);
    int n;
    n = 0;
    while (st !== e && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (st !== e) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic t_out();
    for (int i = 0; i < 16; i++) rd(i, 0);
    w(2, 8'h70);
    w(5, 8'h90);
    w(9, 8'h98);
    ce = 0;
    w(3, 8'h70);
    ce = 1;
    rd(2, 1);
    rd(5, 2);
    rd(9, 3);
    rd(3, 0);
    w(2, 8'h50);
    chk("status_clr", sc, 8'h01);
    rd(2, 1);
    w(5, 8'hff);
    rd(5, 0);
  endtask
  task automatic t_lock();
    logic [7:0] c[3] = '{8'h01, 8'h2f, 8'h03};
    for (int i = 0; i < 3; i++) begin
      w(2, 8'h60);
      chk("state", st, 8'h02);
      w(2, c[i]);
      chk("stb", {ls, lds, cs}, 3'b100 >> i);
      chk("op_bank", ob, 8'h02);
    end
    w(6, 8'h60);
    w(6, 8'h77);
    chk("lock_err", le, 8'h01);
    chk("state", st, 8'h01);
    w(6, 8'h50);
    chk("lock_err", le, 8'h00);
  endtask
  task automatic t_busy();
    hold = 1;
    w(1, 8'h60);
    chk("state", st, 8'h01);
    hold = 0;
    w(1, 8'h60);
    hold = 1;
    w(1, 8'h01);
    chk("state", st, 8'h02);
    hold = 0;
    w(1, 8'h2f);
    chk("state", st, 8'h01);
  endtask
  task automatic t_otp();
    w(8, 8'hc0);
    w(8, 8'h11);
    wait_st(6'h01);
    chk("state", st, 8'h01);
    w(7, 8'hc0);
    chk("state", st, 8'h04);
    w(7, 8'h5a);
    chk("otp_word", ow, 8'h5a);
    chk("otp_start", os, 8'h01);
    chk("state", st, 8'h08);
    w(7, 8'h60);
    chk("state", st, 8'h10);
    wait_st(6'h20);
    w(2, 8'h98);
    rd(2, 1);
    w(2, 8'h50);
    chk("state", st, 8'h01);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    chk("state", st, 8'h01);
    t_out();
    t_lock();
    t_busy();
    t_otp();
    complete_run();
  end
endmodule
`default_nettype wire
